// ---- verilog/rio_unit.sv ----
// Combined 128-byte RAM and two 8-bit parallel ports with port A handshake modes.
//
// Notes on behaviour
// - During reset every port line is undriven and nothing operates.
// - After reset all lines are inputs, basic I/O mode, output latches zero.
// - A one in a direction register bit makes that line an output; handshake modes override the port A direction.
// - Single-bit read returns the pin level in data bit 7, others zero.
// - Single-bit read of an output line returns the value being driven.
// - Single-bit write sets the line latch to address bit 4; data ignored.
// - Whole-byte reads and writes of port A and port B are supported.
// - Mode comes from the top three bits of the mode register only.
// - In handshake modes the port B line 7 latch enables the interrupt.
// - Strobe low latches port A, raises line 6, and raises enabled interrupt.
// - In strobed input a byte read of port A clears interrupt and line 6.
// - In strobed output a byte write to port A drives line 6 low.
// - In strobed output a falling line 7 raises the enabled interrupt.
// - In tri-state output mode port A drives only while line 7 is low.
// - 128 bytes of ordinary read/write memory are provided.
// - RAM and I/O repeat in four 256-byte blocks from 800 hex.
`timescale 1ns/1ps
module rio_unit
   import rio_pkg::*;
#(
   parameter int FIFO_DEPTH = RIO_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire rio_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   output logic bus_rvalid,
   output logic out_fifo_ready,
   input wire logic [7:0] port_a_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   input wire logic [7:0] port_b_in,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   output logic transfer_irq
);

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   logic [7:0] ram [RIO_RAM_WORDS];
   logic [7:0] latch_a;
   logic [7:0] latch_b;
   logic [7:0] port_a_direction;
   logic [7:0] port_b_direction;
   logic [7:0] handshake_mode_select;
   logic [7:0] in_latch;
   logic in_full;
   logic irq_flag;
   logic hs_in_prev;
   logic [7:0] next_latch_a;
   logic [7:0] next_latch_b;
   logic [7:0] next_port_a_direction;
   logic [7:0] next_port_b_direction;
   logic [7:0] next_handshake_mode_select;
   logic [7:0] next_in_latch;
   logic next_in_full;
   logic next_irq_flag;
   rio_pin_drive_t next_drive_a;
   rio_pin_drive_t next_drive_b;
   logic [7:0] next_rdata;
   logic next_irq;

   // ----------------------------------------------------------------
   // Decode.
   // ----------------------------------------------------------------
   rio_mode_t mode;
   logic block_hit;
   logic ram_hit;
   logic bit_hit;
   logic [7:0] off;
   logic hs_in_mode;
   logic hs_out_mode;
   logic strobe_fall;
   logic wr_byte_a;
   logic rd_byte_a;
   logic [7:0] driven_a;
   logic [7:0] driven_b;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic fifo_pop;

   // Only address lines 11 and 8 take part, so the unit shows up at 800, A00, C00 and E00.
   assign block_hit = bus_req.addr[RIO_BLOCK_SEL_BIT] && !bus_req.addr[RIO_BLOCK_GAP_BIT];
   assign off = bus_req.addr[7:0];
   assign ram_hit = block_hit && off[RIO_RAM_SEL_BIT];
   assign bit_hit = block_hit && (off[7:5] == RIO_BIT_AREA);
   // Unknown codes in the top three bits fall back to basic I/O.
   assign mode = rio_mode_t'(handshake_mode_select[7:5]);
   assign hs_in_mode = (mode == RIO_MODE_STROBE_IN);
   assign hs_out_mode = (mode == RIO_MODE_STROBE_OUT) || (mode == RIO_MODE_STROBE_TRI);
   // Line 7 is sampled against its previous level; inputs are synchronous to clk.
   assign strobe_fall = hs_in_prev && !port_b_in[RIO_HS_IN_BIT];
   assign wr_byte_a = block_hit && bus_req.wr && (off == RIO_OFF_PORT_A);
   assign rd_byte_a = block_hit && bus_req.rd && (off == RIO_OFF_PORT_A);
   // The acknowledge edge drains one byte; a slow peripheral lets the buffer fill.
   assign fifo_pop = hs_out_mode && strobe_fall;

   // What each line shows: the driven level where enabled, otherwise the pin.
   assign driven_a = (port_a_oe & port_a_out) | (~port_a_oe & port_a_in);
   assign driven_b = (port_b_oe & port_b_out) | (~port_b_oe & port_b_in);

   // Port A bytes in an output mode queue here until acknowledged.
   rio_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_out_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(wr_byte_a && hs_out_mode),
      .in_ready(fifo_in_ready),
      .in_data(bus_req.wdata),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // ----------------------------------------------------------------
   // Register writes and handshake flags.
   // ----------------------------------------------------------------
   always_comb begin
      next_latch_a = latch_a;
      next_latch_b = latch_b;
      next_port_a_direction = port_a_direction;
      next_port_b_direction = port_b_direction;
      next_handshake_mode_select = handshake_mode_select;
      next_in_latch = in_latch;
      next_in_full = in_full;
      next_irq_flag = irq_flag;
      if (block_hit && bus_req.wr) begin
         if (bit_hit) begin
            // The written level is address bit 4; the data lines play no part.
            if (off[RIO_BIT_PORT_POS]) begin
               next_latch_b[off[2:0]] = off[RIO_BIT_VALUE_POS];
            end else begin
               next_latch_a[off[2:0]] = off[RIO_BIT_VALUE_POS];
            end
         end
         case (off)
            RIO_OFF_PORT_A: begin
               next_latch_a = bus_req.wdata;
            end
            RIO_OFF_PORT_B: begin
               next_latch_b = bus_req.wdata;
            end
            RIO_OFF_DIR_A: begin
               next_port_a_direction = bus_req.wdata;
            end
            RIO_OFF_DIR_B: begin
               next_port_b_direction = bus_req.wdata;
            end
            RIO_OFF_MODE: begin
               next_handshake_mode_select = bus_req.wdata;
               // Writing the mode abandons a half-done input transfer; queued output bytes stay in the FIFO.
               next_in_full = 1'b0;
               next_irq_flag = 1'b0;
            end
            default: begin
               next_latch_a = next_latch_a;
            end
         endcase
      end
      // A port A access clears the interrupt; a new event in the same cycle wins.
      if (hs_in_mode && rd_byte_a) begin
         next_in_full = 1'b0;
         next_irq_flag = 1'b0;
      end
      if (hs_out_mode && wr_byte_a) begin
         next_irq_flag = 1'b0;
      end
      if (hs_in_mode && strobe_fall) begin
         next_in_latch = port_a_in;
         next_in_full = 1'b1;
         next_irq_flag = 1'b1;
      end
      if (fifo_pop && fifo_out_valid) begin
         next_irq_flag = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive, interrupt and read data.
   // ----------------------------------------------------------------
   always_comb begin
      next_drive_a.data = latch_a;
      next_drive_a.oe = port_a_direction;
      next_drive_b.data = latch_b;
      next_drive_b.oe = port_b_direction;
      case (mode)
         RIO_MODE_STROBE_IN: begin
            next_drive_a.oe = 8'h00;
            next_drive_b.data[RIO_HS_OUT_BIT] = in_full;
         end
         RIO_MODE_STROBE_OUT: begin
            next_drive_a.data = fifo_out_data;
            next_drive_a.oe = 8'hff;
            // Low while a byte waits, high again once the last one is acknowledged.
            next_drive_b.data[RIO_HS_OUT_BIT] = !fifo_out_valid;
         end
         RIO_MODE_STROBE_TRI: begin
            next_drive_a.data = fifo_out_data;
            // The bus is released one clock after the acknowledge rises again.
            next_drive_a.oe = port_b_in[RIO_HS_IN_BIT] ? 8'h00 : 8'hff;
            next_drive_b.data[RIO_HS_OUT_BIT] = !fifo_out_valid;
         end
         default: begin
            next_drive_a.oe = port_a_direction;
         end
      endcase
      // The line 7 latch is reused as the interrupt enable while handshaking.
      next_irq = next_irq_flag && latch_b[RIO_HS_IN_BIT] && (hs_in_mode || hs_out_mode);
      next_rdata = 8'h00;
      if (block_hit && bus_req.rd) begin
         if (ram_hit) begin
            next_rdata = ram[off[6:0]];
         end else if (bit_hit) begin
            next_rdata = off[RIO_BIT_PORT_POS] ? {driven_b[off[2:0]], 7'h00}
                                               : {driven_a[off[2:0]], 7'h00};
         end else begin
            case (off)
               RIO_OFF_PORT_A: begin
                  next_rdata = hs_in_mode ? in_latch : (hs_out_mode ? fifo_out_data : driven_a);
               end
               RIO_OFF_PORT_B: begin
                  next_rdata = driven_b;
               end
               RIO_OFF_DIR_A: begin
                  next_rdata = port_a_direction;
               end
               RIO_OFF_DIR_B: begin
                  next_rdata = port_b_direction;
               end
               RIO_OFF_MODE: begin
                  next_rdata = handshake_mode_select;
               end
               default: begin
                  next_rdata = 8'h00;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   // Reset releases every pin and returns all latches to zero and the mode to basic I/O.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         latch_a <= RIO_RST_BYTE;
         latch_b <= RIO_RST_BYTE;
         port_a_direction <= RIO_RST_BYTE;
         port_b_direction <= RIO_RST_BYTE;
         handshake_mode_select <= RIO_RST_BYTE;
         in_latch <= RIO_RST_BYTE;
         in_full <= 1'b0;
         irq_flag <= 1'b0;
         hs_in_prev <= 1'b1;
         port_a_out <= RIO_RST_BYTE;
         port_a_oe <= 8'h00;
         port_b_out <= RIO_RST_BYTE;
         port_b_oe <= 8'h00;
         transfer_irq <= 1'b0;
         bus_rdata <= 8'h00;
         bus_rvalid <= 1'b0;
         out_fifo_ready <= 1'b0;
      end else begin
         latch_a <= next_latch_a;
         latch_b <= next_latch_b;
         port_a_direction <= next_port_a_direction;
         port_b_direction <= next_port_b_direction;
         handshake_mode_select <= next_handshake_mode_select;
         in_latch <= next_in_latch;
         in_full <= next_in_full;
         irq_flag <= next_irq_flag;
         hs_in_prev <= port_b_in[RIO_HS_IN_BIT];
         port_a_out <= next_drive_a.data;
         port_a_oe <= next_drive_a.oe;
         port_b_out <= next_drive_b.data;
         port_b_oe <= next_drive_b.oe;
         transfer_irq <= next_irq;
         bus_rdata <= next_rdata;
         bus_rvalid <= block_hit && bus_req.rd;
         out_fifo_ready <= fifo_in_ready;
      end
   end

   // RAM contents are left as they are through reset, like any plain memory.
   always_ff @(posedge clk) begin
      if (!sys_rst && ram_hit && bus_req.wr) begin
         ram[off[6:0]] <= bus_req.wdata;
      end
   end

endmodule

// ---- verilog/rio_pkg.sv ----
// Package with the address map, mode codes, reset values and bus carrier of the RAM and I/O unit.
package rio_pkg;

   // ----------------------------------------------------------------
   // Address decode.
   // ----------------------------------------------------------------
   localparam logic [11:0] RIO_BLOCK_BASE = 12'h800;
   localparam int RIO_BLOCK_SEL_BIT = 11;
   localparam int RIO_BLOCK_GAP_BIT = 8;
   localparam int RIO_RAM_SEL_BIT = 7;
   localparam int RIO_RAM_WORDS = 128;
   localparam logic [2:0] RIO_BIT_AREA = 3'h0;
   localparam int RIO_BIT_VALUE_POS = 4;
   localparam int RIO_BIT_PORT_POS = 3;
   localparam logic [7:0] RIO_OFF_PORT_A = 8'h20;
   localparam logic [7:0] RIO_OFF_PORT_B = 8'h21;
   localparam logic [7:0] RIO_OFF_DIR_A = 8'h22;
   localparam logic [7:0] RIO_OFF_DIR_B = 8'h23;
   localparam logic [7:0] RIO_OFF_MODE = 8'h24;

   // ----------------------------------------------------------------
   // Handshake lines on port B and reset values.
   // ----------------------------------------------------------------
   localparam int RIO_HS_OUT_BIT = 6;
   localparam int RIO_HS_IN_BIT = 7;
   localparam logic [7:0] RIO_RST_BYTE = 8'h00;
   localparam int RIO_FIFO_DEPTH = 4;

   // Mode is taken from the three high bits of the mode register.
   typedef enum logic [2:0] {
      RIO_MODE_BASIC = 3'h0,
      RIO_MODE_STROBE_IN = 3'h4,
      RIO_MODE_STROBE_OUT = 3'h6,
      RIO_MODE_STROBE_TRI = 3'h7
   } rio_mode_t;

   // One processor bus request.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } rio_bus_req_t;

   // One port's pin drive.
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] oe;
   } rio_pin_drive_t;

endpackage

// ---- verilog/rio_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module rio_fifo
   import rio_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = RIO_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
   localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] wr_ptr;
   logic [PW:0] count;
   logic [PW-1:0] next_rd_ptr;
   logic [PW-1:0] next_wr_ptr;
   logic [PW:0] next_count;
   logic push;
   logic pop;

   // Flags come straight from the held count, never stale.
   assign in_ready = (count != FULL_COUNT);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // ----------------------------------------------------------------
   // Pointer and count update.
   // ----------------------------------------------------------------
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // Storage has no reset; the count tracks emptiness.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule

// ---- verification/rio_unit_chk.sv ----
// Port-level properties of the RAM and parallel I/O unit, bound to its top module.
`timescale 1ns/1ps
module rio_unit_chk
   import rio_pkg::*;
#(
   parameter int FIFO_DEPTH = RIO_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire rio_bus_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   input wire logic bus_rvalid,
   input wire logic out_fifo_ready,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_oe,
   input wire logic [7:0] port_b_in,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_b_oe,
   input wire logic transfer_irq
);
   // -----------------------------------------------------------
   // Shadow of mode, interrupt enable and the last read kind.
   // -----------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic dec;
   logic [7:0] off;
   logic bit_rd, next_bit_rd, irq_en, next_irq_en;
   rio_mode_t md, next_md;
   assign dec = bus_req.addr[11] && !bus_req.addr[8];
   assign off = bus_req.addr[7:0];
   // Mirrors follow bus accesses only, so a wrong internal register shows up.
   always_comb begin
      next_md = md;
      next_irq_en = irq_en;
      next_bit_rd = bit_rd;
      if (dec && bus_req.wr && off == RIO_OFF_MODE) begin
         next_md = (bus_req.wdata[7:5] inside {3'h4, 3'h6, 3'h7}) ? rio_mode_t'(bus_req.wdata[7:5]) : RIO_MODE_BASIC;
      end
      if (dec && bus_req.wr && off[7:5] == 3'h0 && off[3:0] == 4'hf) begin
         next_irq_en = off[4];
      end
      if (dec && bus_req.rd) begin
         next_bit_rd = (off[7:5] == RIO_BIT_AREA);
      end
   end
   // Mirror registers.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         md <= RIO_MODE_BASIC;
         irq_en <= 1'b0;
         bit_rd <= 1'b0;
      end else begin
         md <= next_md;
         irq_en <= next_irq_en;
         bit_rd <= next_bit_rd;
      end
   end
   // -----------------------------------------------------------
   // Assertions.
   // -----------------------------------------------------------
   a_reset_quiet:
      assert property (disable iff (1'b0) sys_rst |=> port_a_oe == 8'h00 && port_b_oe == 8'h00 &&
         port_a_out == 8'h00 && port_b_out == 8'h00 && !transfer_irq && !bus_rvalid) else $error("reset state");
   a_read_answer:
      assert property (bus_req.rd |=> bus_rvalid == $past(dec)) else $error("read answer");
   a_bit_form:
      assert property (bus_rvalid && bit_rd |-> bus_rdata[6:0] == 7'h00) else $error("bit read form");
   a_dir_b:
      assert property (dec && bus_req.wr && off == RIO_OFF_DIR_B |-> ##2 port_b_oe == $past(bus_req.wdata, 2))
         else $error("direction B");
   a_bit_write:
      assert property (md == RIO_MODE_BASIC && dec && bus_req.wr && off[7:5] == 3'h0 && !off[3] |-> ##2
         port_a_out[$past(bus_req.addr[2:0], 2)] == $past(bus_req.addr[4], 2)) else $error("bit write");
   a_strobe_full:
      assert property (md == RIO_MODE_STROBE_IN && $past(md) == md && $fell(port_b_in[7]) |-> ##2 port_b_out[6])
         else $error("buffer full");
   a_read_clears:
      assert property (md == RIO_MODE_STROBE_IN && dec && bus_req.rd && off == RIO_OFF_PORT_A |-> ##2
         !port_b_out[6] && !transfer_irq) else $error("read clear");
   a_write_ready:
      assert property (md == RIO_MODE_STROBE_OUT && dec && bus_req.wr && off == RIO_OFF_PORT_A && out_fifo_ready
         |-> ##2 !port_b_out[6]) else $error("data ready");
   a_ack_irq:
      assert property (md[2:1] == 2'b11 && irq_en && $fell(port_b_in[7]) |-> ##[1:2] transfer_irq)
         else $error("ack interrupt");
   a_irq_gate:
      assert property ((md == RIO_MODE_BASIC || !irq_en) && $past(md) == md && $past(irq_en) == irq_en
         |-> !transfer_irq) else $error("interrupt gate");
   a_tri_float:
      assert property (md == RIO_MODE_STROBE_TRI && $past(md) == md |=>
         port_a_oe == ($past(port_b_in[7]) ? 8'h00 : 8'hff)) else $error("tri-state drive");
   c_strobe_in: cover property (md == RIO_MODE_STROBE_IN && $fell(port_b_in[7]));
   c_fifo_full: cover property (md == RIO_MODE_STROBE_OUT && !out_fifo_ready);
   c_tri_ack: cover property (md == RIO_MODE_STROBE_TRI && port_a_oe == 8'hff);
endmodule

bind rio_unit rio_unit_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
   .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .out_fifo_ready(out_fifo_ready), .port_a_in(port_a_in),
   .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_b_in(port_b_in), .port_b_out(port_b_out),
   .port_b_oe(port_b_oe), .transfer_irq(transfer_irq));

// ---- verification/rio_periph.sv ----
// Behavioural model of the handshaking peripheral on port A and port B lines 6 and 7.
`timescale 1ns/1ps
module rio_periph (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic send,
   input wire logic [7:0] send_data,
   input wire logic ack_en,
   input wire logic ready_line,
   input wire logic [7:0] a_pins,
   output logic strobe,
   output logic [7:0] a_drv,
   output logic a_act,
   output logic got_valid,
   output logic [7:0] got_data
);
   logic [3:0] cnt;
   logic ack_run;
   // One sequencer for both directions; the count paces pulses and gaps.
   always @(posedge clk) begin
      if (sys_rst) begin
         got_valid <= 1'b0;
         strobe <= 1'b1;
         cnt <= 4'h0;
         ack_run <= 1'b0;
         a_act <= 1'b0;
         a_drv <= 8'h00;
         got_data <= 8'h00;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
         if (!ack_run && cnt == 4'h9) strobe <= 1'b0;
         if (!ack_run && cnt == 4'h8) strobe <= 1'b1;
         if (ack_run && cnt == 4'h9) strobe <= 1'b1;
         // Taken while the acknowledge is low, so tri-state drive is seen too.
         got_valid <= ack_run && cnt == 4'ha;
         if (ack_run && cnt == 4'ha) got_data <= a_pins;
         if (!ack_run && cnt == 4'h2) a_drv <= ~a_drv; // Hold time is over: never keep showing the old byte.
      end else if (send) begin
         a_drv <= send_data;
         a_act <= 1'b1;
         ack_run <= 1'b0;
         cnt <= 4'h9;
      end else if (ack_en && !ready_line) begin
         strobe <= 1'b0;
         ack_run <= 1'b1;
         cnt <= 4'hb;
      end
   end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking testbench of the RAM and parallel I/O unit.
`timescale 1ns/1ps
module tb_top;
   import rio_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   rio_bus_req_t req = '0;
   logic [7:0] pa_bench = 8'h00, pb_bench = 8'h00, rnd = 8'h3a, send_data = 8'h00;
   logic send = 1'b0, ack_en = 1'b0;
   logic [7:0] bus_rdata, port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out, port_b_oe, a_drv, got_data;
   logic bus_rvalid, out_fifo_ready, transfer_irq, strobe, a_act, got_valid;
   int miscompares = 0, samples_checked = 0;
   logic [7:0] exp_q[$], out_q[$];
   // -----------------------------------------------------------
   // Clock, pins and instances.
   // -----------------------------------------------------------
   always #20 clk = ~clk;
   // Each pin shows the unit when it drives, else the far side.
   assign port_a_in = (port_a_out & port_a_oe) | (~port_a_oe & (a_act ? a_drv : pa_bench));
   assign port_b_in = (port_b_out & port_b_oe) | (~port_b_oe & {strobe, pb_bench[6:0]});
   rio_unit #(.FIFO_DEPTH(RIO_FIFO_DEPTH)) i_dut (.clk(clk), .sys_rst(sys_rst), .bus_req(req),
      .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .out_fifo_ready(out_fifo_ready), .port_a_in(port_a_in),
      .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_b_in(port_b_in), .port_b_out(port_b_out),
      .port_b_oe(port_b_oe), .transfer_irq(transfer_irq));
   rio_periph i_periph (.clk(clk), .sys_rst(sys_rst), .send(send), .send_data(send_data), .ack_en(ack_en),
      .ready_line(port_b_out[6]), .a_pins(port_a_in), .strobe(strobe), .a_drv(a_drv), .a_act(a_act),
      .got_valid(got_valid), .got_data(got_data));
   // -----------------------------------------------------------
   // Tasks.
   // -----------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check_flag(input string what, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic results;
      if (exp_q.size() != 0 || out_q.size() != 0) miscompares++;
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One access, released at the edge that takes it.
   task automatic bus_op(input logic wr, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{rd: !wr, wr: wr, addr: a, wdata: d};
      @(posedge clk);
      req <= '{rd: 1'b0, wr: 1'b0, addr: a, wdata: d};
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus_op(1'b1, a, d);
   endtask
   task automatic rd_exp(input logic [11:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus_op(1'b0, a, e);
   endtask
   task automatic strobe_in(input logic [7:0] d);
      @(posedge clk);
      send <= 1'b1;
      send_data <= d;
      @(posedge clk);
      send <= 1'b0;
   endtask
   // Bounded wait for line 6; the next check catches a timeout.
   task automatic wait_hs(input logic v);
      int n;
      n = 0;
      while (port_b_out[6] !== v && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   // -----------------------------------------------------------
   // Result monitor and watchdog.
   // -----------------------------------------------------------
   always @(negedge clk) begin
      if (bus_rvalid === 1'b1) begin
         if (exp_q.size() == 0) check_byte("unexpected read", 8'h00, bus_rdata);
         else check_byte("bus_rdata", exp_q.pop_front(), bus_rdata);
      end
      if (got_valid === 1'b1) begin
         if (out_q.size() == 0) check_byte("extra byte", 8'h00, got_data);
         else check_byte("port_a data", out_q.pop_front(), got_data);
      end
   end
   initial begin
      #800000;
      miscompares++;
      results();
   end
   // -----------------------------------------------------------
   // Main sequence.
   // -----------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      pb_bench <= 8'h5b;
      pa_bench <= lfsr(rnd);
      rd_exp(12'h822, 8'h00);
      rd_exp(12'h823, 8'h00);
      rd_exp(12'h824, 8'h00);
      rd_exp(12'h830, 8'h00);
      bus_op(1'b0, 12'h920, 8'h00);
      rd_exp(12'h80b, {pb_bench[3], 7'h00});
      rd_exp(12'h802, {pa_bench[2], 7'h00});
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         wr({1'b1, 2'(i), 2'b01, 7'(i * 29)}, rnd);
         rd_exp({1'b1, 2'(3 - i), 2'b01, 7'(i * 29)}, rnd);
      end
      wr(12'h823, 8'h80);
      rd_exp(12'h823, 8'h80);
      rd_exp(12'h821, {1'b0, pb_bench[6:0]});
      wr(12'h822, 8'hff);
      rnd = lfsr(rnd);
      wr(12'h820, rnd);
      rd_exp(12'h820, rnd);
      rd_exp(12'h805, {rnd[5], 7'h00});
      wr(12'h815, 8'h00);
      rd_exp(12'h805, 8'h80);
      wr(12'h805, 8'hff);
      rd_exp(12'h805, 8'h00);
      // Strobed input, interrupt enabled, then inhibited.
      wr(12'h822, 8'h00);
      wr(12'h823, 8'h40);
      wr(12'h81f, 8'h00);
      wr(12'h824, {3'h4, rnd[4:0]});
      for (int i = 0; i < 4; i++) begin
         if (i == 3) wr(12'h80f, 8'hff);
         rnd = lfsr(rnd);
         strobe_in(rnd);
         wait_hs(1'b1);
         repeat (2) @(posedge clk);
         #1;
         check_flag("transfer_irq", i < 3, transfer_irq);
         rd_exp(12'h820, rnd);
         wait_hs(1'b0);
         check_flag("transfer_irq", 1'b0, transfer_irq);
      end
      // Strobed output: fill the buffer, then drain.
      wr(12'h81f, 8'h00);
      wr(12'h824, {3'h6, rnd[4:0]});
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         out_q.push_back(rnd);
         wr(12'h820, rnd);
      end
      repeat (2) @(posedge clk);
      #1;
      check_flag("out_fifo_ready", 1'b0, out_fifo_ready);
      check_flag("handshake_out_line", 1'b0, port_b_out[6]);
      wr(12'h820, 8'h5a);
      @(posedge clk);
      ack_en <= 1'b1;
      @(posedge clk);
      wait_hs(1'b1);
      check_flag("handshake_out_line", 1'b1, port_b_out[6]);
      check_flag("transfer_irq", 1'b1, transfer_irq);
      // Tri-state output.
      ack_en <= 1'b0;
      wr(12'h824, 8'he0);
      out_q.push_back(rnd);
      wr(12'h820, rnd);
      repeat (2) @(posedge clk);
      #1;
      check_flag("port_a_oe idle", 1'b1, port_a_oe === 8'h00);
      ack_en <= 1'b1;
      for (int n = 0; n < 50 && strobe !== 1'b0; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      #1;
      check_flag("port_a_oe ack", 1'b1, port_a_oe === 8'hff);
      wait_hs(1'b1);
      repeat (2) @(posedge clk);
      #1;
      check_flag("port_a_oe after", 1'b1, port_a_oe === 8'h00);
      results();
   end
endmodule
